// *** picture_adjust_regs.svh ***
`ifndef PICTURE_ADJUST_REGS_SVH
`define PICTURE_ADJUST_REGS_SVH
// How it works
// RULE1: Composite black is 64 plus scaled offset
// RULE2: Composite luma gain uses contrast multiplier formula
// RULE3: Composite chroma gain is setting over 128
// RULE4: Signed hue, blocked for component and SECAM
// RULE5: Three chroma features work in any combination
// RULE6: Each frame feature needs 16 Mbit, both 32
// RULE7: Host configures memory before enabling frame features; host_port_model enables them with no memory setup
// RULE8: Temporal off selects 2D five-line comb
// RULE9: Timebase field: off, on, automatic
// RULE10: Chroma comb enable is active low, composite
// RULE11: Denoise off at reset, never on progressive
// RULE12: Auto chroma gain field has four modes
// RULE13: Phase compensation ignored in NTSC, SECAM
// RULE14: Wide lowpass on at reset, notch select
// RULE15: Component colour gains are settings over 128; RGB input keeps both colour-difference gains at unity
// RULE16: Component luma gain is setting over 128; RGB input keeps luma gain at unity
// RULE17: Component black is 64 plus plain offset; RGB input keeps black at 64 with no offset
// RULE18: Blanking select can gate window in blanking
// RULE19: Window start also places start code
// RULE20: Window stop places end code, even count
// RULE21: Ten-bit values commit on high byte write
// RULE22: Timing values kept per video standard
// RULE23: Sync start is ten bits, resets zero
// RULE24: Multipliers come from range extender register
// RULE25: Reserved bits read zero, writes ignored

// ==========================================
// Subaddresses
`define OFS_BLACK      8'h09
`define OFS_LGAIN      8'h0a
`define OFS_CGAIN      8'h0b
`define OFS_HUE        8'h0c
`define OFS_FEAT       8'h0d
`define OFS_FILT       8'h0e
`define OFS_PR         8'h10
`define OFS_Y          8'h11
`define OFS_PB         8'h12
`define OFS_YBLACK     8'h14
`define OFS_START_LO   8'h16
`define OFS_START_HI   8'h17
`define OFS_STOP_LO    8'h18
`define OFS_STOP_HI    8'h19
`define OFS_HS_LO      8'h1a
`define OFS_HS_HI      8'h1b
// ==========================================
// Reset values and write masks
`define RST_MID        8'h80
`define RST_ZERO       8'h00
`define RST_FILT       8'h0c
`define MASK_FEAT      8'hef
`define MASK_FILT      8'h0f
`define RST_START_525  10'h055
`define RST_START_625  10'h05f
`define RST_STOP_525   10'h325
`define RST_STOP_625   10'h32f
`define RST_HS         10'h000
// ==========================================
// Field positions
`define BIT_TEMPORAL   7
`define BIT_TBC_HI     6
`define BIT_TBC_LO     5
`define BIT_COMB_N     3
`define BIT_DENOISE    2
`define BIT_PHASE      3
`define BIT_WIDE       2
`define BIT_BLANK_SEL  2
// ==========================================
// Arithmetic constants
`define NOM_BLACK      13'h0040
`define MID_CODE       9'h080
`define UNITY_GAIN     24'h01_0000
`define MEM_UNIT       6'h10
`endif

// *** picture_adjust_pkg.sv ***
`include "picture_adjust_regs.svh"
package picture_adjust_pkg;
	// Input signal class from the input selector
	typedef enum logic [1:0] {
		CLS_CVBS  = 2'h0,
		CLS_SVID  = 2'h1,
		CLS_YPBPR = 2'h3,
		CLS_RGB   = 2'h2
	} video_class_t;
	typedef enum logic [1:0] {
		TBC_OFF = 2'h0, TBC_ON = 2'h1, TBC_AUTO = 2'h2
	} tbc_mode_t;
	typedef enum logic [1:0] {
		ACG_AUTO = 2'h0, ACG_RSVD = 2'h1,
		ACG_NOMINAL = 2'h2, ACG_FROZEN = 2'h3
	} acg_mode_t;
	typedef logic [15:0][9:0] std_tab_t;
	// Whole block state
	typedef struct packed {
		logic [7:0]        bright, lgain, cgain, hue, feat, filt;
		logic [7:0]        pr, y, pb, yblack;
		logic              blank_sel;
		logic [7:0]        start_lo, stop_lo, hs_lo;
		std_tab_t          start_tab, stop_tab, hs_tab;
		logic [7:0]        rdata;
		logic signed [12:0] black;
		logic signed [23:0] luma_g;
		logic [23:0]       chroma_g, pr_g, pb_g;
		logic [7:0]        hue_out;
		logic              window, sav, eav, hs_mark;
	} state_t;
	// 625-line standards take the second default set
	function automatic std_tab_t std_defaults(
			logic [9:0] v525, logic [9:0] v625);
		std_tab_t t;
		for (int i = 0; i < 16; i++) begin
			t[i] = (i == 2 || i == 4 || i == 6 || i == 10) ?
				v625 : v525;
		end
		return t;
	endfunction
endpackage

// *** picture_adjust_timing_regs.sv ***
module picture_adjust_timing_regs
	import picture_adjust_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire logic               reg_wr,
	input  wire logic [7:0]         reg_addr,
	input  wire logic [7:0]         reg_wdata,
	output logic [7:0]              reg_rdata,
	input  wire logic [3:0]         video_std,
	input  wire logic [3:0]         bright_mult,
	input  wire logic [3:0]         contrast_mult,
	input  wire video_class_t       video_class,
	input  wire logic               secam_mode,
	input  wire logic               ntsc_mode,
	input  wire logic               progressive,
	input  wire logic [9:0]         pixel_pos,
	input  wire logic               vertical_blank_interval,
	output logic signed [12:0]      black_level,
	output logic signed [23:0]      luma_gain,
	output logic [23:0]             chroma_gain,
	output logic [23:0]             red_diff_gain,
	output logic [23:0]             blue_diff_gain,
	output logic [7:0]              hue_rotation,
	output logic                    temporal_yc_separation,
	output logic                    comb_2d_en,
	output logic                    frame_recursive_denoise,
	output tbc_mode_t               line_timebase_correction,
	output logic                    chroma_comb_en,
	output acg_mode_t               auto_chroma_gain,
	output logic                    phase_alt_compensation,
	output logic                    wide_chroma_lowpass,
	output logic [1:0]              chroma_notch_sel,
	output logic [5:0]              frame_mem_mbits,
	output logic                    active_video_window,
	output logic                    sav_mark,
	output logic                    eav_mark,
	output logic                    horizontal_sync
);

	// ==========================================
	// State
	localparam state_t RST = '{
		bright:    `RST_MID,
		lgain:     `RST_MID,
		cgain:     `RST_MID,
		hue:       `RST_ZERO,
		feat:      `RST_ZERO,
		filt:      `RST_FILT,
		pr:        `RST_MID,
		y:         `RST_MID,
		pb:        `RST_MID,
		yblack:    `RST_MID,
		start_tab: std_defaults(`RST_START_525, `RST_START_625),
		stop_tab:  std_defaults(`RST_STOP_525, `RST_STOP_625),
		hs_tab:    std_defaults(`RST_HS, `RST_HS),
		default:   '0
	};

	state_t s_r;     // Registered state
	state_t s_nxt;   // Next state

	// Working values of the current standard
	logic [9:0]         cur_start;
	logic [9:0]         cur_stop;
	logic [9:0]         cur_hs;
	logic               is_comp;     // YPbPr or RGB
	logic signed [8:0]  bofs;        // Offset from mid code
	logic signed [5:0]  bmul;        // Multiplier plus one
	logic signed [14:0] bprod;
	logic [23:0]        lscaled;
	logic signed [23:0] lterm;

	assign cur_start = s_r.start_tab[video_std];
	assign cur_stop  = s_r.stop_tab[video_std];
	assign cur_hs    = s_r.hs_tab[video_std];
	assign is_comp   = video_class[1];

	// ==========================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		// Register writes, reserved bits dropped
		if (reg_wr) begin
			case (reg_addr)
				`OFS_BLACK:  s_nxt.bright = reg_wdata;
				`OFS_LGAIN:  s_nxt.lgain  = reg_wdata;
				`OFS_CGAIN:  s_nxt.cgain  = reg_wdata;
				`OFS_HUE:    s_nxt.hue    = reg_wdata;
				`OFS_FEAT:   s_nxt.feat   = reg_wdata & `MASK_FEAT; // see RULE25
				`OFS_FILT:   s_nxt.filt   = reg_wdata & `MASK_FILT; // see RULE25
				`OFS_PR:     s_nxt.pr     = reg_wdata;
				`OFS_Y:      s_nxt.y      = reg_wdata;
				`OFS_PB:     s_nxt.pb     = reg_wdata;
				`OFS_YBLACK: s_nxt.yblack = reg_wdata;
				// Low bytes only stage
				`OFS_START_LO: s_nxt.start_lo = reg_wdata; // see RULE21
				`OFS_STOP_LO:  s_nxt.stop_lo  = reg_wdata; // see RULE21
				`OFS_HS_LO:    s_nxt.hs_lo    = reg_wdata; // see RULE21
				// High byte commits into this standard's slot
				`OFS_START_HI: begin
					s_nxt.blank_sel = reg_wdata[`BIT_BLANK_SEL];
					s_nxt.start_tab[video_std] =
						{reg_wdata[1:0], s_r.start_lo}; // see RULE21, RULE22
				end
				`OFS_STOP_HI: begin
					s_nxt.stop_tab[video_std] =
						{reg_wdata[1:0], s_r.stop_lo}; // see RULE21, RULE22
				end
				`OFS_HS_HI: begin
					s_nxt.hs_tab[video_std] =
						{reg_wdata[1:0], s_r.hs_lo}; // see RULE23, RULE22
				end
				default: begin
					// Other subaddresses live elsewhere
				end
			endcase
		end

		// Read data, one cycle behind the address
		case (reg_addr)
			`OFS_BLACK:    s_nxt.rdata = s_r.bright;
			`OFS_LGAIN:    s_nxt.rdata = s_r.lgain;
			`OFS_CGAIN:    s_nxt.rdata = s_r.cgain;
			`OFS_HUE:      s_nxt.rdata = s_r.hue;
			`OFS_FEAT:     s_nxt.rdata = s_r.feat;
			`OFS_FILT:     s_nxt.rdata = s_r.filt;
			`OFS_PR:       s_nxt.rdata = s_r.pr;
			`OFS_Y:        s_nxt.rdata = s_r.y;
			`OFS_PB:       s_nxt.rdata = s_r.pb;
			`OFS_YBLACK:   s_nxt.rdata = s_r.yblack;
			`OFS_START_LO: s_nxt.rdata = cur_start[7:0];
			`OFS_START_HI: s_nxt.rdata = {5'h00, s_r.blank_sel,
				cur_start[9:8]}; // see RULE25
			`OFS_STOP_LO:  s_nxt.rdata = cur_stop[7:0];
			`OFS_STOP_HI:  s_nxt.rdata = {6'h00, cur_stop[9:8]};
			`OFS_HS_LO:    s_nxt.rdata = cur_hs[7:0];
			`OFS_HS_HI:    s_nxt.rdata = {6'h00, cur_hs[9:8]};
			default:       s_nxt.rdata = 8'h00;
		endcase

		// Black level: multiplier only on the composite path
		if (video_class == CLS_YPBPR) begin
			s_nxt.black = 13'($signed({5'h00, s_r.yblack})
				- $signed({4'h0, `MID_CODE})
				+ $signed(`NOM_BLACK)); // see RULE17
		end else if (is_comp) begin
			// RGB offset belongs to the analogue front end
			s_nxt.black = `NOM_BLACK; // see RULE17
		end else begin
			s_nxt.black = 13'(bprod
				+ $signed(`NOM_BLACK)); // see RULE1, RULE24
		end

		// Luma gain, 16 fractional bits
		if (video_class == CLS_YPBPR) begin
			s_nxt.luma_g = $signed({7'h00, s_r.y,
				9'h000}); // see RULE16
		end else if (is_comp) begin
			// RGB gain belongs to the analogue front end
			s_nxt.luma_g = `UNITY_GAIN; // see RULE16
		end else begin
			s_nxt.luma_g = $signed(lscaled) + lterm; // see RULE2
		end

		// Chroma gains; RGB keeps nominal colour-difference gain
		s_nxt.chroma_g = {7'h00, s_r.cgain, 9'h000}; // see RULE3
		if (video_class == CLS_YPBPR) begin
			s_nxt.pr_g = {7'h00, s_r.pr, 9'h000}; // see RULE15
			s_nxt.pb_g = {7'h00, s_r.pb, 9'h000}; // see RULE15
		end else begin
			s_nxt.pr_g = `UNITY_GAIN;
			s_nxt.pb_g = `UNITY_GAIN;
		end

		// Hue is meaningless without a subcarrier phase
		if (is_comp || secam_mode) begin
			s_nxt.hue_out = 8'h00; // see RULE4
		end else begin
			s_nxt.hue_out = s_r.hue; // see RULE4
		end

		// Active window, start inclusive, stop exclusive
		s_nxt.window = (pixel_pos >= cur_start)
			&& (pixel_pos < cur_stop)
			&& !(s_r.blank_sel
			&& vertical_blank_interval); // see RULE18
		s_nxt.sav     = (pixel_pos == cur_start); // see RULE19
		s_nxt.eav     = (pixel_pos == cur_stop); // see RULE20
		s_nxt.hs_mark = (pixel_pos == cur_hs); // see RULE23

		if (!resetn) begin
			s_nxt = RST;
		end
	end

	// Composite brightness and contrast arithmetic
	always_comb begin
		bofs    = $signed({1'b0, s_r.bright}) - $signed(`MID_CODE);
		bmul    = $signed({1'b0, 5'(bright_mult) + 5'h01});
		bprod   = 15'(bmul * bofs); // see RULE1
		lscaled = {6'h00, s_r.lgain, 10'h000} >> contrast_mult;
		lterm   = $signed({4'h0, contrast_mult, 16'h0000})
			- $signed(`UNITY_GAIN); // see RULE2, RULE24
	end

	// ==========================================
	// Register
	always_ff @(posedge clk) begin
		s_r <= s_nxt;
	end

	// ==========================================
	// Outputs
	assign reg_rdata           = s_r.rdata;
	assign black_level         = s_r.black;
	assign luma_gain           = s_r.luma_g;
	assign chroma_gain         = s_r.chroma_g;
	assign red_diff_gain       = s_r.pr_g;
	assign blue_diff_gain      = s_r.pb_g;
	assign hue_rotation        = s_r.hue_out;
	assign active_video_window = s_r.window;
	assign sav_mark            = s_r.sav;
	assign eav_mark            = s_r.eav;
	assign horizontal_sync     = s_r.hs_mark;

	// Each feature decodes from its own bits; the 2D comb is the inverse of the temporal bit
	assign temporal_yc_separation = s_r.feat[`BIT_TEMPORAL]; // see RULE5
	assign comb_2d_en = !s_r.feat[`BIT_TEMPORAL]; // see RULE8
	// Progressive frames break the field recursion
	assign frame_recursive_denoise = s_r.feat[`BIT_DENOISE]
		&& !progressive; // see RULE11
	// Both automatic codes map to one mode
	assign line_timebase_correction = s_r.feat[`BIT_TBC_HI] ?
		TBC_AUTO : (s_r.feat[`BIT_TBC_LO] ?
		TBC_ON : TBC_OFF); // see RULE9
	assign chroma_comb_en = !s_r.feat[`BIT_COMB_N]
		&& (video_class == CLS_CVBS); // see RULE10
	assign auto_chroma_gain = acg_mode_t'(s_r.feat[1:0]); // see RULE12
	assign phase_alt_compensation = s_r.filt[`BIT_PHASE]
		&& !ntsc_mode && !secam_mode; // see RULE13
	assign wide_chroma_lowpass = s_r.filt[`BIT_WIDE]; // see RULE14
	assign chroma_notch_sel = s_r.filt[1:0]; // see RULE14
	// Memory budget; host must set up memory first
	assign frame_mem_mbits =
		(temporal_yc_separation ? `MEM_UNIT : 6'h00)
		+ (s_r.feat[`BIT_DENOISE] ? `MEM_UNIT : 6'h00); // see RULE6, RULE7

	// ==========================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_msb_commit: assert property ( // see RULE21
		reg_wr && reg_addr == `OFS_START_HI
		|=> s_r.start_tab[$past(video_std)]
			== {$past(reg_wdata[1:0]), $past(s_r.start_lo)})
		else $error("start not committed on high byte");
	a_lsb_staged: assert property ( // see RULE21
		reg_wr && reg_addr == `OFS_STOP_LO
		|=> $stable(s_r.stop_tab))
		else $error("low byte changed live stop value");
	a_std_hold: assert property ( // see RULE22
		!reg_wr |=> $stable(s_r.hs_tab) && $stable(s_r.start_tab))
		else $error("timing table changed without write");
	a_hue_blocked: assert property ( // see RULE4
		secam_mode || is_comp |=> hue_rotation == 8'h00)
		else $error("hue applied to component or SECAM");
	a_comb_cvbs: assert property ( // see RULE10
		chroma_comb_en |-> video_class == CLS_CVBS
			&& !s_r.feat[`BIT_COMB_N])
		else $error("chroma comb on outside composite");
	a_no_prog_nr: assert property ( // see RULE11
		progressive |-> !frame_recursive_denoise)
		else $error("denoise on progressive input");
	a_mem_double: assert property ( // see RULE6
		temporal_yc_separation && s_r.feat[`BIT_DENOISE]
		|-> frame_mem_mbits == 6'h20)
		else $error("combined memory not 32 Mbit");
	a_blank_gate: assert property ( // see RULE18
		s_r.blank_sel && vertical_blank_interval
		|=> !active_video_window)
		else $error("window active in gated blanking");
	a_filt_reset: assert property ( // see RULE14
		@(posedge clk) disable iff (1'b0)
		!resetn |=> s_r.filt == `RST_FILT)
		else $error("chroma filter reset value wrong");
	a_rsvd_zero: assert property ( // see RULE25
		reg_addr == `OFS_FILT |=> reg_rdata[7:4] == 4'h0)
		else $error("reserved bits read nonzero");
	a_comp_black: assert property ( // see RULE17
		is_comp && $stable(s_r.yblack) && s_r.yblack == `RST_MID
		|=> black_level == 13'sd64)
		else $error("component black not nominal");

	// Timing marks follow the committed table of the current standard
	a_sav_place: assert property ( // see RULE19
		pixel_pos == cur_start |=> sav_mark)
		else $error("start code missing at window start");
	a_eav_place: assert property ( // see RULE20
		pixel_pos == cur_stop |=> eav_mark)
		else $error("end code missing at window stop");
	a_sync_place: assert property ( // see RULE23
		pixel_pos == cur_hs |=> horizontal_sync)
		else $error("sync mark missing at sync start");
	// Ungated window must be open for every active pixel
	a_window_open: assert property ( // see RULE18
		!s_r.blank_sel && pixel_pos >= cur_start
		&& pixel_pos < cur_stop |=> active_video_window)
		else $error("window closed inside active pixels");
	// Low bytes only stage, high bytes commit
	a_hs_staged: assert property ( // see RULE21
		reg_wr && reg_addr == `OFS_HS_LO |=> $stable(s_r.hs_tab))
		else $error("low byte changed live sync value");
	a_stop_commit: assert property ( // see RULE21, RULE22
		reg_wr && reg_addr == `OFS_STOP_HI
		|=> s_r.stop_tab[$past(video_std)]
			== {$past(reg_wdata[1:0]), $past(s_r.stop_lo)})
		else $error("stop not committed on high byte");
	// RGB gains and offset are owned by the front end
	a_rgb_nominal: assert property ( // see RULE15, RULE16, RULE17
		video_class == CLS_RGB |=> red_diff_gain == `UNITY_GAIN
			&& blue_diff_gain == `UNITY_GAIN
			&& luma_gain == `UNITY_GAIN
			&& black_level == `NOM_BLACK)
		else $error("component settings applied to RGB");
	// Mid-code saturation means nominal chroma gain
	a_chroma_unity: assert property ( // see RULE3
		s_r.cgain == `RST_MID |=> chroma_gain == `UNITY_GAIN)
		else $error("chroma gain not nominal at mid code");
	a_tbc_auto: assert property ( // see RULE9
		s_r.feat[`BIT_TBC_HI] |-> line_timebase_correction == TBC_AUTO)
		else $error("timebase codes 10 and 11 not automatic");

	c_commit: cover property (
		reg_wr && reg_addr == `OFS_START_LO
		##1 reg_wr && reg_addr == `OFS_START_HI);
	c_both_mem: cover property (frame_mem_mbits == 6'h20);
	c_window: cover property (sav_mark ##[1:900] eav_mark);
	c_rgb_input: cover property (video_class == CLS_RGB
		##1 luma_gain == `UNITY_GAIN);
	c_tbc_auto: cover property (line_timebase_correction == TBC_AUTO);
endmodule

// *** host_port_model.sv ***
// ==========================================
// Host side of the register port
module host_port_model (
	input  wire logic       clk,
	output logic            reg_wr,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// One-cycle strobe; data scrambled afterwards so stale data never counts
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~v;
	endtask
	// Read data is registered, so it is taken one edge after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		#1;
		reg_addr = a;
		@(posedge clk);
		#1;
		v = reg_rdata;
	endtask
	// Frame memory features are enabled with no memory setup here
	// because this host never owns a memory controller
endmodule

// *** picture_adjust_timing_regs_tb.sv ***
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module picture_adjust_timing_regs_tb;
	import picture_adjust_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// Stimulus and observed signals
	logic clk = 1'b0, resetn = 1'b0, reg_wr;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, f;
	logic [3:0] video_std = 4'h0, bright_mult = 4'h0, contrast_mult = 4'h0;
	video_class_t video_class = CLS_CVBS;
	logic secam_mode = 0, ntsc_mode = 0, progressive = 0;
	logic vertical_blank_interval = 0, bs, comp;
	logic [9:0] pixel_pos = 10'h000, st, sp, hs, p;
	logic signed [12:0] black_level;
	logic signed [23:0] luma_gain;
	logic [23:0] chroma_gain, red_diff_gain, blue_diff_gain;
	logic [7:0] hue_rotation, v[8];
	logic temporal_yc_separation, comb_2d_en, frame_recursive_denoise;
	logic chroma_comb_en, phase_alt_compensation, wide_chroma_lowpass;
	logic active_video_window, sav_mark, eav_mark, horizontal_sync;
	tbc_mode_t line_timebase_correction;
	acg_mode_t auto_chroma_gain;
	logic [1:0] chroma_notch_sel;
	logic [5:0] frame_mem_mbits;
	int miscompares = 0, n_checks = 0;
	// Picture registers in write order
	localparam logic [7:0] AD[8] = '{8'h09, 8'h0a, 8'h0b, 8'h0c,
		8'h10, 8'h11, 8'h12, 8'h14};
	// Reset image: address in high byte, value in low byte
	localparam logic [15:0] RV[17] = '{16'h0980, 16'h0a80, 16'h0b80,
		16'h0c00, 16'h0d00, 16'h0e0c, 16'h1080, 16'h1180, 16'h1280,
		16'h1480, 16'h1655, 16'h1700, 16'h1825, 16'h1903, 16'h1a00,
		16'h1b00, 16'h1300};
	always #10 clk = ~clk;
	picture_adjust_timing_regs picture_adjust_timing_regs_i (.clk, .resetn,
		.reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .video_std,
		.bright_mult, .contrast_mult, .video_class, .secam_mode,
		.ntsc_mode, .progressive, .pixel_pos, .vertical_blank_interval,
		.black_level, .luma_gain, .chroma_gain, .red_diff_gain,
		.blue_diff_gain, .hue_rotation, .temporal_yc_separation,
		.comb_2d_en, .frame_recursive_denoise, .line_timebase_correction,
		.chroma_comb_en, .auto_chroma_gain, .phase_alt_compensation,
		.wide_chroma_lowpass, .chroma_notch_sel, .frame_mem_mbits,
		.active_video_window, .sav_mark, .eav_mark, .horizontal_sync);
	host_port_model host_port_model_i (.clk, .reg_wr, .reg_addr,
		.reg_wdata, .reg_rdata);
	// ==========================================
	// Expected arithmetic
	// RGB offsets and gains live in the analogue front end
	function automatic logic signed [12:0] exp_black(logic [7:0] b, y);
		if (video_class == CLS_RGB) return 13'sh0040;
		if (comp) return 13'(64 + int'(y) - 128);
		return 13'(64 + (int'(bright_mult) + 1) * (int'(b) - 128));
	endfunction
	// Truncated to 16 fraction bits, as the gain path does
	function automatic logic signed [23:0] exp_luma(logic [7:0] c, y);
		if (video_class == CLS_RGB) return 24'sh01_0000;
		if (comp) return {7'h00, y, 9'h000};
		return 24'((int'(c) << 16) >> (6 + contrast_mult))
			+ 24'((int'(contrast_mult) - 1) << 16);
	endfunction
	// Colour-difference gain: setting over 128, RGB stays nominal
	function automatic logic [23:0] exp_diff(logic [7:0] s);
		if (video_class == CLS_RGB) return 24'h01_0000;
		return {7'h00, s, 9'h000};
	endfunction
	// Single exit point for every outcome
	task automatic report_and_stop();
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'h637bb9f8));
		repeat (3) @(posedge clk);
		#1;
		resetn = 1'b1;
		// Arithmetic outputs settle one edge after release
		@(posedge clk);
		#1;
		// Reset image, including an unmapped hole at 13h
		`CHK(black_level, 13'sh0040)
		`CHK(chroma_gain, 24'h01_0000)
		foreach (RV[i]) begin
			host_port_model_i.rd(RV[i][15:8], d);
			`CHK(d, RV[i][7:0])
		end
		// Random picture settings across composite and component inputs
		repeat (40) begin
			bright_mult = 4'($urandom);
			contrast_mult = 4'($urandom);
			video_class = video_class_t'(2'($urandom));
			comp = video_class[1];
			secam_mode = 1'($urandom);
			foreach (v[i]) begin
				v[i] = 8'($urandom);
				host_port_model_i.wr(AD[i], v[i]);
			end
			repeat (3) @(posedge clk);
			#1;
			`CHK(black_level, exp_black(v[0], v[7]))
			`CHK(luma_gain, exp_luma(v[1], v[5]))
			if (!comp) begin
				`CHK(chroma_gain, {7'h00, v[2], 9'h000})
				`CHK(hue_rotation, secam_mode ? 8'h00 : v[3])
			end else begin
				`CHK(red_diff_gain, exp_diff(v[4]))
				`CHK(blue_diff_gain, exp_diff(v[6]))
				`CHK(hue_rotation, 8'h00)
			end
		end
		// Every code of both chroma control bytes, any input and mode
		for (int i = 0; i < 256; i++) begin
			f = 8'(i);
			progressive = 1'($urandom);
			video_class = video_class_t'(2'($urandom));
			ntsc_mode = 1'($urandom);
			secam_mode = 1'($urandom);
			host_port_model_i.wr(8'h0d, f);
			host_port_model_i.wr(8'h0e, f);
			host_port_model_i.rd(8'h0d, d);
			`CHK(d, f & 8'hef)
			host_port_model_i.rd(8'h0e, d);
			`CHK(d, f & 8'h0f)
			`CHK(temporal_yc_separation, f[7])
			`CHK(comb_2d_en, ~f[7])
			`CHK(line_timebase_correction, f[6] ? TBC_AUTO : tbc_mode_t'({1'b0, f[5]}))
			`CHK(chroma_comb_en, ~f[3] & (video_class == CLS_CVBS))
			`CHK(frame_recursive_denoise, f[2] & ~progressive)
			`CHK(auto_chroma_gain, acg_mode_t'(f[1:0]))
			`CHK(frame_mem_mbits, 6'(16 * (f[7] + f[2])))
			`CHK(phase_alt_compensation, f[3] & ~ntsc_mode & ~secam_mode)
			`CHK(wide_chroma_lowpass, f[2])
			`CHK(chroma_notch_sel, f[1:0])
		end
		// Window timing, forced standard first, even pixel count
		video_std = 4'h1;
		st = 10'($urandom_range(40, 200));
		sp = st + 10'(2 * $urandom_range(50, 300));
		hs = 10'($urandom);
		host_port_model_i.wr(8'h16, st[7:0]);
		host_port_model_i.rd(8'h16, d);
		`CHK(d, 8'h55)
		host_port_model_i.wr(8'h17, {5'h00, 1'b1, st[9:8]});
		host_port_model_i.rd(8'h17, d);
		`CHK(d, {5'h00, 1'b1, st[9:8]})
		host_port_model_i.wr(8'h18, sp[7:0]);
		host_port_model_i.wr(8'h19, {6'h00, sp[9:8]});
		host_port_model_i.wr(8'h1a, hs[7:0]);
		host_port_model_i.wr(8'h1b, {6'h00, hs[9:8]});
		video_std = 4'h2;
		host_port_model_i.rd(8'h16, d);
		`CHK(d, 8'h5f)
		host_port_model_i.rd(8'h18, d);
		`CHK(d, 8'h2f)
		video_std = 4'h1;
		host_port_model_i.rd(8'h18, d);
		`CHK(d, sp[7:0])
		// Blank gating on, then off; positions hug the edges
		for (int k = 0; k < 2; k++) begin
			bs = (k == 0);
			host_port_model_i.wr(8'h17, {5'h00, bs, st[9:8]});
			repeat (150) begin
				case ($urandom_range(0, 6))
					0: p = st - 10'h001;
					1: p = st;
					2: p = sp - 10'h001;
					3: p = sp;
					4: p = hs;
					default: p = 10'($urandom);
				endcase
				@(posedge clk);
				#1;
				pixel_pos = p;
				vertical_blank_interval = 1'($urandom);
				@(posedge clk);
				#1;
				`CHK(active_video_window, p >= st && p < sp && !(bs && vertical_blank_interval))
				`CHK(sav_mark, p == st)
				`CHK(eav_mark, p == sp)
				`CHK(horizontal_sync, p == hs)
			end
		end
		report_and_stop();
	end
endmodule
